// file: design/php_defines.svh
`ifndef PHP_DEFINES_SVH
`define PHP_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PHP_OFS_CTRL 12'h000
`define PHP_OFS_SHAPE 12'h004
`define PHP_OFS_THR 12'h008
`define PHP_OFS_BLR 12'h00C
`define PHP_OFS_CHAN 12'h010
`define PHP_OFS_STAT 12'h014
`define PHP_OFS_REALT 12'h018
`define PHP_OFS_ACQT 12'h01C
`define PHP_OFS_DEADT 12'h020
`define PHP_SCA_BASE 4'h4
`define PHP_HIST_MAIN 2'h1
`define PHP_HIST_SETUP 2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PHP_CTRL_RST 12'h000
`define PHP_SHAPE_RST 16'h0208
`define PHP_THR_RST 32'h0020_0040
`define PHP_BLR_RST 24'h001004

// ----------------------------------------------------------------
// clocking and timing
// ----------------------------------------------------------------
`define PHP_CLK_HZ 64'd250000000
`define PHP_RATE20_HZ 64'd20000000
`define PHP_RATE80_HZ 64'd80000000
`define PHP_FAST_PK_NS_20 64'd400
`define PHP_FAST_PK_NS_80 64'd100
`define PHP_NS_PER_S 64'd1000000000
`define PHP_BLR_FRAC 8
`define PHP_HIST_MAX 32'hFFFF_FFFF

`endif

// file: design/php_pkg.sv
package php_pkg;

  // control word, bit 11 downward
  typedef struct packed {
    logic [3:0] gain;
    logic [1:0] scope_sel;
    logic dac_en;
    logic hold;
    logic list_mode;
    logic rate80;
    logic clear;
    logic run;
  } php_ctrl_t;

  // one list-mode record
  typedef struct packed {
    logic [11:0] amp;
    logic [31:0] tag;
  } php_event_t;

  // pulse tracker states, gray along idle-pulse-lock
  typedef enum logic [1:0] {
    PHP_IDLE = 2'b00,
    PHP_PULSE = 2'b01,
    PHP_LOCK = 2'b11
  } php_state_t;

endpackage : php_pkg

// file: design/php_hist.sv
`include "php_defines.svh"

module php_hist (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clr_i,
  input wire logic inc_i,
  input wire logic [5:0] inc_addr_i,
  input wire logic [5:0] rd_addr_i,
  output logic [31:0] rd_data_o
);

  // ----------------------------------------------------------------
  // counter bank, one word per channel
  // ----------------------------------------------------------------
  logic [31:0] cnt_r [64];

  assign rd_data_o = cnt_r[rd_addr_i];

  // an increment in the clear cycle is kept, so no event is lost
  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_cnt
      wire hit = inc_i && (inc_addr_i == 6'(g));
      wire full = (cnt_r[g] == `PHP_HIST_MAX);
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          cnt_r[g] <= 32'h0000_0000;
        end else if (clr_i) begin
          cnt_r[g] <= {31'h0000_0000, hit};
        end else if (hit && !full) begin
          cnt_r[g] <= cnt_r[g] + 32'h0000_0001;
        end
      end
    end
  endgenerate

endmodule : php_hist

// file: design/php_core.sv
`include "php_defines.svh"

// Operation
// - sample clock runs at 20 or 80 MHz, chosen by control bit.
// - one 12-bit digitized sample enters the chain per sample clock.
// - pipelined datapath shapes every sample continuously, never pausing.
// - slow filter forms a trapezoid with configurable peaking time.
// - peak detector emits one maximum value per shaped pulse.
// - shaped pulse optionally drives the diagnostic DAC, nothing depends on it.
// - pile-up and risetime checks discard bad events before the histogram.
// - dead time is counted directly in logic.
// - each accepted event increments the counter addressed by its peak.
// - eight window discriminators plus a selectable digital scope output.
// - host starts, stops, clears and sets gain and shaping; device obeys.
// - a channel offset is subtracted when mapping peaks to channels.
// - list mode outputs amplitude and time tag instead of the main histogram; rejects still build the setup spectrum.
// - peaking setting counts sample clocks, so 80 MHz is four times shorter.
// - fast channel peaks in 400 ns at 20 MHz, 100 ns at 80 MHz.
// - reset lockout and baseline restorer settings count sample clocks.
// - rejected events build a separate setup spectrum.
// - acquisition halts while the hold bit is set; acquisition time counts apart from real time.
module php_core (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [11:0] adc_data_i,
  input wire logic det_reset_i,
  output logic adc_clk_o,
  output logic [3:0] ana_gain_o,
  output logic [11:0] dac_o,
  output logic [11:0] scope_o,
  output logic [7:0] sca_o,
  output logic ev_valid_o,
  output php_pkg::php_event_t ev_o,
  output logic acq_active_o
);

  // ----------------------------------------------------------------
  // clock-derived constants
  // ----------------------------------------------------------------
  localparam logic [31:0] NCO_INC20 = 32'((`PHP_RATE20_HZ << 32) / `PHP_CLK_HZ);
  localparam logic [31:0] NCO_INC80 = 32'((`PHP_RATE80_HZ << 32) / `PHP_CLK_HZ);
  localparam logic [6:0] FAST_K20 = 7'(`PHP_FAST_PK_NS_20 * `PHP_RATE20_HZ / `PHP_NS_PER_S);
  localparam logic [6:0] FAST_K80 = 7'(`PHP_FAST_PK_NS_80 * `PHP_RATE80_HZ / `PHP_NS_PER_S);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  php_pkg::php_ctrl_t ctrl_r;
  logic [15:0] shape_r; // [4:0] peaking samples, [12:8] flat top samples
  logic [31:0] thr_r; // [15:0] slow, [29:16] fast
  logic [23:0] blr_r; // [3:0] baseline shift, [23:8] lockout samples
  logic [23:0] chan_r; // [11:0] channel offset, [23:16] risetime limit
  logic [31:0] sca_win_r [8]; // [5:0] low, [21:16] high
  logic [31:0] real_r, acq_r, dead_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire setup_ph = psel_i && !penable_i;
  wire wr_acc = psel_i && penable_i && pwrite_i;
  wire [1:0] hist_sel = paddr_i[9:8];
  wire is_hist = (paddr_i[11:10] == 2'h0) &&
                 (hist_sel == `PHP_HIST_MAIN || hist_sel == `PHP_HIST_SETUP);
  wire is_sca = (paddr_i[11:5] == {3'h0, `PHP_SCA_BASE} >> 1) && (paddr_i[1:0] == 2'h0);
  wire [31:0] hist_main_rd, hist_setup_rd;
  logic [31:0] rd_mux;
  logic rd_ok;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // status, time counters and spectra refuse writes
  wire ro_hit = is_hist || hit(paddr_i, `PHP_OFS_STAT) || hit(paddr_i, `PHP_OFS_REALT) ||
                hit(paddr_i, `PHP_OFS_ACQT) || hit(paddr_i, `PHP_OFS_DEADT);
  php_pkg::php_state_t state_r;
  wire state_busy = (state_r != php_pkg::PHP_IDLE);

  // read selection; unmapped addresses answer zero with an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (is_hist) begin
      rd_mux = (hist_sel == `PHP_HIST_MAIN) ? hist_main_rd : hist_setup_rd;
    end else if (is_sca) begin
      rd_mux = sca_win_r[paddr_i[4:2]];
    end else if (hit(paddr_i, `PHP_OFS_CTRL)) begin
      rd_mux = {20'h0_0000, ctrl_r};
    end else if (hit(paddr_i, `PHP_OFS_SHAPE)) begin
      rd_mux = {16'h0000, shape_r};
    end else if (hit(paddr_i, `PHP_OFS_THR)) begin
      rd_mux = thr_r;
    end else if (hit(paddr_i, `PHP_OFS_BLR)) begin
      rd_mux = {8'h00, blr_r};
    end else if (hit(paddr_i, `PHP_OFS_CHAN)) begin
      rd_mux = {8'h00, chan_r};
    end else if (hit(paddr_i, `PHP_OFS_STAT)) begin
      rd_mux = {30'h0000_0000, state_busy, acq_active_o};
    end else if (hit(paddr_i, `PHP_OFS_REALT)) begin
      rd_mux = real_r;
    end else if (hit(paddr_i, `PHP_OFS_ACQT)) begin
      rd_mux = acq_r;
    end else if (hit(paddr_i, `PHP_OFS_DEADT)) begin
      rd_mux = dead_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read data captured in setup, so access phase answers at once
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_r <= pwrite_i ? !(rd_ok && !ro_hit) : !rd_ok;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && pslverr_r;

  // writable registers; clear is a self-clearing strobe
  wire wr_ok = wr_acc && !pslverr_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= `PHP_CTRL_RST;
      shape_r <= `PHP_SHAPE_RST;
      thr_r <= `PHP_THR_RST;
      blr_r <= `PHP_BLR_RST;
      chan_r <= 24'h00_0000;
    end else begin
      ctrl_r.clear <= 1'b0;
      if (wr_ok && hit(paddr_i, `PHP_OFS_CTRL)) ctrl_r <= pwdata_i[11:0];
      if (wr_ok && hit(paddr_i, `PHP_OFS_SHAPE)) shape_r <= pwdata_i[15:0];
      if (wr_ok && hit(paddr_i, `PHP_OFS_THR)) thr_r <= pwdata_i;
      if (wr_ok && hit(paddr_i, `PHP_OFS_BLR)) blr_r <= pwdata_i[23:0];
      if (wr_ok && hit(paddr_i, `PHP_OFS_CHAN)) chan_r <= pwdata_i[23:0];
    end
  end

  genvar w;
  generate
    for (w = 0; w < 8; w++) begin : g_sca_reg
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          sca_win_r[w] <= 32'h0000_0000;
        end else if (wr_ok && is_sca && paddr_i[4:2] == 3'(w)) begin
          sca_win_r[w] <= pwdata_i & 32'h003F_003F;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sample clock and input capture
  // ----------------------------------------------------------------
  logic [31:0] nco_r;
  logic nco_msb_r, samp_stb_r;
  logic [11:0] adc_m_r, adc_s_r;
  logic rst_m_r, rst_s_r;

  // phase accumulator gives the average rate; jitter is one system clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nco_r <= 32'h0000_0000;
      nco_msb_r <= 1'b0;
      samp_stb_r <= 1'b0;
      adc_m_r <= 12'h000;
      adc_s_r <= 12'h000;
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      nco_r <= nco_r + (ctrl_r.rate80 ? NCO_INC80 : NCO_INC20);
      nco_msb_r <= nco_r[31];
      samp_stb_r <= nco_r[31] && !nco_msb_r;
      adc_m_r <= adc_data_i;
      adc_s_r <= adc_m_r;
      rst_m_r <= det_reset_i;
      rst_s_r <= rst_m_r;
    end
  end

  assign adc_clk_o = nco_msb_r;

  // ----------------------------------------------------------------
  // baseline restorer and shaping pipeline
  // ----------------------------------------------------------------
  logic [19:0] blr_acc_r;
  logic signed [13:0] dly_r [128];
  logic [6:0] wp_r;
  logic signed [23:0] slow_r;
  logic signed [13:0] fast_r;

  wire signed [13:0] x_in = $signed({2'b00, adc_s_r}) -
                            $signed({2'b00, blr_acc_r[19:`PHP_BLR_FRAC]});
  wire [6:0] k_pk = (shape_r[4:0] == 5'h00) ? 7'h01 : {2'b00, shape_r[4:0]};
  wire [6:0] k_l = k_pk + {2'b00, shape_r[12:8]};
  wire [6:0] k_f = ctrl_r.rate80 ? FAST_K80 : FAST_K20;

  // delayed sample d cycles back from the write pointer
  function automatic logic signed [13:0] tap(input logic [6:0] d);
    tap = dly_r[wp_r - d];
  endfunction : tap

  wire signed [15:0] trap_d = 16'(x_in) - 16'(tap(k_pk)) - 16'(tap(k_l)) +
                              16'(tap(7'(k_pk + k_l)));
  wire signed [13:0] fast_nxt = x_in - tap(k_f);
  wire [19:0] blr_err = {adc_s_r, 8'h00} - blr_acc_r;

  // every sample strobe advances the whole pipeline, with no gaps
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // the slow sum never forgets, so an unknown tap would spoil it for good
      for (int i = 0; i < 128; i++) dly_r[i] <= 14'sh0000;
      wp_r <= 7'h00;
      slow_r <= 24'sh00_0000;
      fast_r <= 14'sh0000;
      blr_acc_r <= 20'h0_0000;
    end else if (samp_stb_r) begin
      dly_r[wp_r] <= x_in;
      wp_r <= wp_r + 7'h01;
      slow_r <= slow_r + 24'(trap_d);
      fast_r <= fast_nxt;
      if (state_r == php_pkg::PHP_IDLE) begin
        blr_acc_r <= blr_acc_r + 20'($signed(blr_err) >>> blr_r[3:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // peak detection and pulse selection
  // ----------------------------------------------------------------
  logic [15:0] lock_cnt_r;
  logic [23:0] peak_r;
  logic [7:0] rise_r;
  logic [1:0] ftrig_r;
  logic fast_above_r, ev_stb_r, ev_ok_r;
  php_pkg::php_state_t state_nxt;

  assign acq_active_o = ctrl_r.run && !ctrl_r.hold;
  wire slow_above = slow_r > $signed({8'h00, thr_r[15:0]});
  wire fast_edge = (fast_r > $signed(thr_r[29:16])) && !fast_above_r;
  wire rt_bad = (chan_r[23:16] != 8'h00) && (rise_r > chan_r[23:16]);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      php_pkg::PHP_IDLE: if (rst_s_r) state_nxt = php_pkg::PHP_LOCK;
                         else if (slow_above && acq_active_o) state_nxt = php_pkg::PHP_PULSE;
      php_pkg::PHP_PULSE: if (rst_s_r) state_nxt = php_pkg::PHP_LOCK;
                          else if (!slow_above) state_nxt = php_pkg::PHP_IDLE;
      php_pkg::PHP_LOCK: if (!rst_s_r && lock_cnt_r == 16'h0000) state_nxt = php_pkg::PHP_IDLE;
      default: state_nxt = php_pkg::PHP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= php_pkg::PHP_IDLE;
      lock_cnt_r <= 16'h0000;
      peak_r <= 24'h00_0000;
      rise_r <= 8'h00;
      ftrig_r <= 2'h0;
      fast_above_r <= 1'b0;
      ev_stb_r <= 1'b0;
      ev_ok_r <= 1'b0;
    end else begin
      ev_stb_r <= 1'b0;
      if (samp_stb_r) begin
        state_r <= state_nxt;
        fast_above_r <= fast_r > $signed(thr_r[29:16]);
        lock_cnt_r <= rst_s_r ? blr_r[23:8] :
                      (lock_cnt_r != 16'h0000) ? lock_cnt_r - 16'h0001 : lock_cnt_r;
        if (state_r == php_pkg::PHP_IDLE) begin
          peak_r <= 24'h00_0000;
          rise_r <= 8'h00;
          ftrig_r <= {1'b0, fast_edge};
        end else if (state_r == php_pkg::PHP_PULSE) begin
          if (fast_edge && ftrig_r != 2'h3) ftrig_r <= ftrig_r + 2'h1;
          if (slow_r > $signed(peak_r)) begin
            peak_r <= slow_r;
            rise_r <= (rise_r == 8'hFF) ? rise_r : rise_r + 8'h01;
          end
          if (state_nxt == php_pkg::PHP_IDLE) begin
            ev_stb_r <= 1'b1;
            ev_ok_r <= (ftrig_r < 2'h2) && !rt_bad;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // time counters, all in sample clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      real_r <= 32'h0000_0000;
      acq_r <= 32'h0000_0000;
      dead_r <= 32'h0000_0000;
    end else if (ctrl_r.clear) begin
      real_r <= 32'h0000_0000;
      acq_r <= 32'h0000_0000;
      dead_r <= 32'h0000_0000;
    end else if (samp_stb_r && ctrl_r.run) begin
      real_r <= real_r + 32'h0000_0001;
      if (acq_active_o) acq_r <= acq_r + 32'h0000_0001;
      if (acq_active_o && state_busy) dead_r <= dead_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // channel mapping, spectra, list mode and window outputs
  // ----------------------------------------------------------------
  wire [23:0] peak_g = peak_r >> ctrl_r.gain;
  wire [11:0] amp = (peak_g[23:12] != 12'h000) ? 12'hFFF : peak_g[11:0];
  wire in_spec = (amp >= chan_r[11:0]) && ((amp - chan_r[11:0]) < 12'h040);
  wire [5:0] chan = 6'(amp - chan_r[11:0]);
  wire main_inc = ev_stb_r && ev_ok_r && in_spec && !ctrl_r.list_mode;
  wire setup_inc = ev_stb_r && !ev_ok_r && in_spec;

  php_hist u_hist_main (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clr_i(ctrl_r.clear),
    .inc_i(main_inc),
    .inc_addr_i(chan),
    .rd_addr_i(paddr_i[7:2]),
    .rd_data_o(hist_main_rd)
  );

  php_hist u_hist_setup (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clr_i(ctrl_r.clear),
    .inc_i(setup_inc),
    .inc_addr_i(chan),
    .rd_addr_i(paddr_i[7:2]),
    .rd_data_o(hist_setup_rd)
  );

  // list record and windows update one cycle after the event
  logic [7:0] sca_r;
  generate
    for (w = 0; w < 8; w++) begin : g_sca
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          sca_r[w] <= 1'b0;
        end else begin
          sca_r[w] <= ev_stb_r && ev_ok_r && in_spec &&
                      (chan >= sca_win_r[w][5:0]) && (chan <= sca_win_r[w][21:16]);
        end
      end
    end
  endgenerate

  // scope output: raw, fast or slow stage; dac follows slow only when enabled
  wire [11:0] scope_nxt = (ctrl_r.scope_sel == 2'h0) ? adc_s_r :
                          (ctrl_r.scope_sel == 2'h1) ? 12'(fast_r) : 12'(slow_r >>> 4);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_valid_o <= 1'b0;
      ev_o <= '0;
      dac_o <= 12'h000;
      scope_o <= 12'h000;
    end else begin
      ev_valid_o <= ev_stb_r && ev_ok_r && ctrl_r.list_mode;
      if (ev_stb_r && ev_ok_r && ctrl_r.list_mode) ev_o <= {amp, real_r};
      dac_o <= ctrl_r.dac_en ? 12'(slow_r >>> 4) : 12'h000;
      scope_o <= scope_nxt;
    end
  end

  assign sca_o = sca_r;
  assign ana_gain_o = ctrl_r.gain;

endmodule : php_core

// file: dv/php_core_props.sv
module php_core_props (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic adc_clk_o,
  input wire logic [3:0] ana_gain_o,
  input wire logic [11:0] dac_o,
  input wire logic [7:0] sca_o,
  input wire logic ev_valid_o,
  input wire logic acq_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // shadow of the control word
  // ----------------------------------------------------------------
  logic [11:0] ctrl_r;
  wire logic acc = psel_i & penable_i;
  wire logic wr_ctrl = acc & pwrite_i & pready_o & (paddr_i == 12'h000);
  wire logic acq_exp = ctrl_r[0] & ~ctrl_r[4];

  // written only on the access edge, as the slave does
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= 12'h000;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata_i[11:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_gain;
    $stable(ctrl_r) [*2] |-> ana_gain_o == ctrl_r[11:8];
  endproperty
  a_gain: assert property (p_gain) else $error("gain code off control word");
  property p_acq;
    $stable(ctrl_r) [*2] |-> acq_active_o == acq_exp;
  endproperty
  a_acq: assert property (p_acq) else $error("acquire flag wrong");
  property p_dac;
    ($stable(ctrl_r) && !ctrl_r[5]) [*2] |-> dac_o == 12'h000;
  endproperty
  a_dac: assert property (p_dac) else $error("dac driven while off");
  property p_ready;
    acc |-> pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_unmap;
    acc && paddr_i >= 12'h300 |-> pslverr_o && (pwrite_i || prdata_o == 32'h0000_0000);
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
  property p_rostat;
    acc && pwrite_i && (paddr_i == 12'h014 || paddr_i == 12'h018) |-> pslverr_o;
  endproperty
  a_rostat: assert property (p_rostat) else $error("status write accepted");
  property p_noerr;
    acc && paddr_i <= 12'h010 && paddr_i[1:0] == 2'h0 |-> !pslverr_o;
  endproperty
  a_noerr: assert property (p_noerr) else $error("setting access refused");
  property p_evpulse;
    ev_valid_o |=> !ev_valid_o;
  endproperty
  a_evpulse: assert property (p_evpulse) else $error("record strobe too long");
  property p_evlist;
    ev_valid_o |-> ctrl_r[3];
  endproperty
  a_evlist: assert property (p_evlist) else $error("record outside list mode");
  property p_adcclk;
    $rose(adc_clk_o) |-> ##[1:7] !adc_clk_o;
  endproperty
  a_adcclk: assert property (p_adcclk) else $error("sample clock stuck high");

  c_ev: cover property (ev_valid_o);
  c_sca: cover property (|sca_o);
  c_err: cover property (acc && pslverr_o);
endmodule : php_core_props

// file: dv/php_adc_model.sv
module php_adc_model #(
  parameter logic [11:0] BASE = 12'h100,
  parameter logic [11:0] STEP = 12'h100
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic adc_clk_i,
  input wire logic fire_i,
  input wire logic det_i,
  output logic [11:0] adc_data_o,
  output logic det_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic adc_q;
  logic pend;
  wire logic rise = adc_clk_i & ~adc_q;

  // staircase like a charge preamp; detector reset comes from the bench
  assign det_reset_o = det_i;

  // a pending step lands right after the next sample clock rise
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      adc_q <= 1'b0;
      pend <= 1'b0;
      adc_data_o <= BASE;
    end else begin
      adc_q <= adc_clk_i;
      pend <= fire_i | (pend & ~rise);
      if (rise && pend) begin
        adc_data_o <= adc_data_o + STEP;
      end
    end
  end
endmodule : php_adc_model

// file: dv/tb.sv
`define CHK(a, b) begin checks++; if ((a) !== (b)) bad(32'(a)); end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, s0, s1, g0, g1, a0, r0;
  logic pready, pslverr, er, adc_clk, det_rst, acq, ev_valid;
  logic ev_seen = 1'b0, sca_seen = 1'b0, adc_q = 1'b0, det = 1'b0;
  logic [11:0] adc_data, dac, scope;
  logic [3:0] gain;
  logic [7:0] sca;
  php_pkg::php_event_t ev, ev_cap;
  int error_cnt = 0, checks = 0, cyc = 0, rises = 0;

  php_core dut (.clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .adc_data_i(adc_data), .det_reset_i(det_rst),
    .adc_clk_o(adc_clk), .ana_gain_o(gain), .dac_o(dac), .scope_o(scope), .sca_o(sca),
    .ev_valid_o(ev_valid), .ev_o(ev), .acq_active_o(acq));
  php_adc_model u_adc (.clk_i(clk), .reset_n_i(rst_n), .adc_clk_i(adc_clk), .fire_i(fire),
    .det_i(det), .adc_data_o(adc_data), .det_reset_o(det_rst));

  // ----------------------------------------------------------------
  // clock, watchdog and monitors
  // ----------------------------------------------------------------
  initial forever #2 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
    if (adc_clk && !adc_q) rises++;
    adc_q <= adc_clk;
    if (ev_valid) ev_seen <= 1'b1;
    if (ev_valid) ev_cap <= ev;
    if (sca[0]) sca_seen <= 1'b1;
  end

  task bad(input logic [31:0] v);
    error_cnt++;
    $display("BAD %0t mismatch, got %0h", $time, v);
  endtask : bad

  task tally_and_finish;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // bus and stimulus helpers
  // ----------------------------------------------------------------
  // request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task hsum(input logic [11:0] base, output logic [31:0] s);
    s = 32'h0;
    for (int i = 0; i < 64; i++) begin
      apb(1'b0, base + 12'(4 * i), 32'h0);
      s = s + rd;
    end
  endtask : hsum

  // one detector step, then time for the shaped pulse to die out
  task pulse;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (400) @(posedge clk);
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h0000_0208)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd, 32'h0020_0040)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(rd, 32'h0000_1004)
    apb(1'b0, 12'h300, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, 12'h014, 32'hFFFF_FFFF);
    `CHK(er, 1'b1)
    apb(1'b1, 12'h018, 32'h0);
    `CHK(er, 1'b1)
  endtask : t_regs

  // 250 clocks is 1 us: 20 rises at 20 MHz, 80 at 80 MHz
  task t_rate;
    apb(1'b1, 12'h000, 32'h0);
    repeat (50) @(posedge clk);
    rises = 0;
    repeat (250) @(posedge clk);
    `CHK(rises >= 19 && rises <= 21, 1'b1)
    apb(1'b1, 12'h000, 32'h4);
    repeat (50) @(posedge clk);
    rises = 0;
    repeat (250) @(posedge clk);
    `CHK(rises >= 79 && rises <= 81, 1'b1)
  endtask : t_rate

  task t_hist;
    `CHK(scope, adc_data)
    hsum(12'h100, s0);
    pulse();
    hsum(12'h100, s1);
    `CHK(s1, s0 + 32'h1)
    `CHK(sca_seen, 1'b1)
    apb(1'b0, 12'h020, 32'h0);
    `CHK(rd != 32'h0, 1'b1)
  endtask : t_hist

  task t_pile;
    hsum(12'h100, s0);
    hsum(12'h200, g0);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (31) @(posedge clk);
    pulse();
    hsum(12'h100, s1);
    hsum(12'h200, g1);
    `CHK(s1, s0)
    `CHK(g1, g0 + 32'h1)
  endtask : t_pile

  task t_offset;
    hsum(12'h100, s0);
    apb(1'b1, 12'h010, 32'h0000_0FFF);
    pulse();
    apb(1'b1, 12'h010, 32'h0);
    hsum(12'h100, s1);
    `CHK(s1, s0)
  endtask : t_offset

  task t_hold;
    hsum(12'h100, s0);
    apb(1'b1, 12'h000, 32'h0000_0615);
    @(posedge clk);
    `CHK(acq, 1'b0)
    apb(1'b0, 12'h01C, 32'h0);
    a0 = rd;
    apb(1'b0, 12'h018, 32'h0);
    r0 = rd;
    pulse();
    apb(1'b0, 12'h01C, 32'h0);
    `CHK(rd, a0)
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd > r0, 1'b1)
    apb(1'b1, 12'h000, 32'h0000_0605);
    hsum(12'h100, s1);
    `CHK(s1, s0)
  endtask : t_hold

  task t_list;
    hsum(12'h100, s0);
    apb(1'b1, 12'h000, 32'h0000_060D);
    ev_seen = 1'b0;
    pulse();
    `CHK(ev_seen, 1'b1)
    apb(1'b0, 12'h018, 32'h0);
    `CHK(ev_cap.tag != 32'h0 && ev_cap.tag <= rd && ev_cap.amp < 12'h040, 1'b1)
    apb(1'b1, 12'h000, 32'h0000_0605);
    hsum(12'h100, s1);
    `CHK(s1, s0)
  endtask : t_list

  // a step inside the reset lockout must not reach the spectrum
  task t_lock;
    hsum(12'h100, s0);
    det <= 1'b1;
    pulse();
    det <= 1'b0;
    repeat (100) @(posedge clk);
    hsum(12'h100, s1);
    `CHK(s1, s0)
  endtask : t_lock

  task t_clear;
    apb(1'b1, 12'h000, 32'h0000_0607);
    hsum(12'h100, s1);
    `CHK(s1, 32'h0)
  endtask : t_clear

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_rate();
    // window 0..63 on the first discriminator, gain 6, 80 MHz, running
    apb(1'b1, 12'h040, 32'h003F_0000);
    apb(1'b1, 12'h000, 32'h0000_0605);
    repeat (200) @(posedge clk);
    t_hist();
    t_pile();
    t_offset();
    t_hold();
    t_list();
    t_lock();
    t_clear();
    tally_and_finish();
  end
endmodule : tb

bind php_core php_core_props u_props (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .adc_clk_o, .ana_gain_o, .dac_o,
  .sca_o, .ev_valid_o, .acq_active_o);
